// [inc/crt_pkg.sv]
/*
 * Constants for the CRT command and status port: command codes,
 * parameter counts, field positions and status bit positions.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package crt_pkg;
  localparam int          CMD_MSB     = 7;
  localparam int          CMD_LSB     = 5;
  localparam logic [2:0]  OP_RESET    = 3'h0;
  localparam logic [2:0]  OP_START    = 3'h1;
  localparam logic [2:0]  OP_STOP     = 3'h2;
  localparam logic [2:0]  OP_CURSOR   = 3'h4;
  localparam logic [2:0]  OP_IEN      = 3'h5;
  localparam logic [2:0]  OP_IDIS     = 3'h6;
  localparam logic [2:0]  OP_PRESET   = 3'h7;
  localparam logic [2:0]  NPAR_RESET  = 3'h4;
  localparam logic [2:0]  NPAR_CURSOR = 3'h2;
  localparam logic [2:0]  NPAR_NONE   = 3'h0;
  localparam logic [2:0]  PIDX_0      = 3'h0;
  localparam logic [2:0]  PIDX_1      = 3'h1;
  localparam logic [2:0]  PIDX_2      = 3'h2;
  localparam logic [2:0]  PIDX_3      = 3'h3;
  localparam int          ST_IE       = 6;
  localparam int          ST_IR       = 5;
  localparam int          ST_IC       = 3;
  localparam int          ST_VE       = 2;
  localparam int          ST_BU       = 1;
  localparam int          B1_SPACED   = 7;
  localparam int          B4_MODE     = 7;
  localparam int          UL_EDGE_BIT = 3;
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [5:0]  HRET_BASE   = 6'h02;
  localparam int          PRESET_CYC  = 2;

  typedef enum logic [1:0] {
    PR_IDLE = 2'h0,
    PR_LOAD = 2'h1,
    PR_HOLD = 2'h3
  } crt_preset_t;

  function automatic logic [2:0] crt_npar(input logic [2:0] op);
    crt_npar = (op == OP_RESET) ? NPAR_RESET : (op == OP_CURSOR) ? NPAR_CURSOR : NPAR_NONE;
  endfunction

  function automatic logic [5:0] crt_hret(input logic [3:0] z);
    crt_hret = {1'b0, z, 1'b0} + HRET_BASE;
  endfunction
endpackage

// [inc/crt_ctl_if.sv]
/*
 * Internal carrier between the port top, the sequence checker and the
 * status flags. Assumes all three run on one clock.
 */
`timescale 1ns/1ps
interface crt_ctl_if;
  logic       cmd_wr;
  logic       par_wr;
  logic       st_rd;
  logic [2:0] op;
  logic [2:0] par_idx;
  logic       par_ok;
  logic       bad_evt;
  logic       last_row;
  logic       swap_miss;
  logic       ie;
  logic       ir;
  logic       ic;
  logic       ve;
  logic       bu;

  modport seq (input cmd_wr, par_wr, op, output par_idx, par_ok, bad_evt);
  modport flg (input cmd_wr, op, st_rd, bad_evt, last_row, swap_miss, output ie, ir, ic, ve, bu);
  modport top (output cmd_wr, par_wr, st_rd, op, last_row, swap_miss,
               input par_idx, par_ok, bad_evt, ie, ir, ic, ve, bu);
endinterface

// [rtl/crt_seq.sv]
/*
 * Counts parameter bytes against the count the last command expects
 * and flags short or long strings. Assumes one write per clock at most.
 */
`timescale 1ns/1ps
module crt_seq (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  crt_ctl_if.seq    ctl
);
  logic [2:0] cnt_q, cnt_d, exp_q, exp_d;
  logic       bad_q, bad_d;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    bad_d = 1'b0;
    if (ctl.cmd_wr) begin
      bad_d = (cnt_q != exp_q);
      exp_d = crt_pkg::crt_npar(ctl.op);
      cnt_d = crt_pkg::NPAR_NONE;
    end else if (ctl.par_wr) begin
      if (cnt_q == exp_q) begin
        bad_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 3'h0;
      exp_q <= 3'h0;
      bad_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
      bad_q <= bad_d;
    end
  end

  assign ctl.par_idx = cnt_q;
  assign ctl.par_ok  = ctl.par_wr && (cnt_q != exp_q);
  assign ctl.bad_evt = bad_q;

  a_seq_short: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ctl.cmd_wr && (cnt_q != exp_q) |=> bad_q) else $error("short string not flagged");
  a_seq_long: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ctl.par_wr && !ctl.cmd_wr && (cnt_q == exp_q) |=> bad_q && $stable(cnt_q))
    else $error("long string not flagged");
endmodule

// [rtl/crt_flags.sv]
/*
 * Status flags: interrupt enable, request pending, bad sequence,
 * video on and row underrun. Assumes pulses from the top, one clock.
 */
`timescale 1ns/1ps
module crt_flags (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  crt_ctl_if.flg    ctl
);
  logic ie_q, ie_d, ir_q, ir_d, ic_q, ic_d, ve_q, ve_d, bu_q, bu_d;
  logic is_reset;

  always_comb begin
    is_reset = ctl.cmd_wr && (ctl.op == crt_pkg::OP_RESET);
    ie_d = ie_q;
    ve_d = ve_q;
    if (ctl.cmd_wr) begin
      unique case (ctl.op)
        crt_pkg::OP_RESET: begin
          ie_d = 1'b0;
          ve_d = 1'b0;
        end
        crt_pkg::OP_START: begin
          ie_d = 1'b1;
          ve_d = 1'b1;
        end
        crt_pkg::OP_STOP:  ve_d = 1'b0;
        crt_pkg::OP_IEN:   ie_d = 1'b1;
        crt_pkg::OP_IDIS:  ie_d = 1'b0;
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    ir_d = (ie_q && ctl.last_row) || (ir_q && !ctl.st_rd && !is_reset);
    ic_d = ctl.bad_evt || (ic_q && !ctl.st_rd);
    bu_d = ctl.swap_miss || (bu_q && !ctl.st_rd);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ie_q <= 1'b0;
      ir_q <= 1'b0;
      ic_q <= 1'b0;
      ve_q <= 1'b0;
      bu_q <= 1'b0;
    end else begin
      ie_q <= ie_d;
      ir_q <= ir_d;
      ic_q <= ic_d;
      ve_q <= ve_d;
      bu_q <= bu_d;
    end
  end

  assign ctl.ie = ie_q;
  assign ctl.ir = ir_q;
  assign ctl.ic = ic_q;
  assign ctl.ve = ve_q;
  assign ctl.bu = bu_q;
endmodule

// [rtl/crt_cmd_port.sv]
/*
 * Command and parameter interpreter with status word for a small CRT
 * controller, running on the character clock. Assumes host strobes
 * are one clock wide and synchronous; raster counters, row buffers
 * and retrace generation sit outside and use the outputs here.
 */
`timescale 1ns/1ps
module crt_cmd_port #(
  parameter int PRESET_CYCLES = crt_pkg::PRESET_CYC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       host_wr_i,
  input  wire logic       host_rd_i,
  input  wire logic       cmd_select_i,
  input  wire logic [7:0] host_wdata_i,
  input  wire logic       last_row_start_i,
  input  wire logic       swap_need_i,
  input  wire logic       row_filled_i,
  input  wire logic       frame_retrace_i,
  output logic      [7:0] host_rdata_o,
  output logic            irq_o,
  output logic            row_load_request_o,
  output logic            blanking_out_o,
  output logic            counter_preset_o,
  output logic            counters_frozen_o,
  output logic            spaced_rows_o,
  output logic      [6:0] chars_per_row_o,
  output logic      [1:0] vretrace_rows_o,
  output logic      [5:0] rows_per_frame_o,
  output logic      [3:0] underline_line_o,
  output logic            edge_blank_o,
  output logic      [3:0] lines_per_row_o,
  output logic            line_mode_o,
  output logic      [1:0] cursor_format_o,
  output logic      [5:0] hretrace_chars_o,
  output logic      [7:0] cursor_char_o,
  output logic      [7:0] cursor_row_o
);
  if (PRESET_CYCLES < 1 || PRESET_CYCLES > 15) begin : g_chk
    $error("PRESET_CYCLES out of range");
  end

  crt_ctl_if ctl ();

  crt_seq u_seq (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .ctl       (ctl)
  );

  crt_flags u_flags (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .ctl       (ctl)
  );

  // Host access decode
  logic       cmd_wr, par_wr, st_rd, swap_miss, retrace_end, fr_prev_q;
  logic [2:0] op;

  always_comb begin
    cmd_wr      = host_wr_i && cmd_select_i;
    par_wr      = host_wr_i && !cmd_select_i;
    st_rd       = host_rd_i && cmd_select_i;
    op          = host_wdata_i[crt_pkg::CMD_MSB:crt_pkg::CMD_LSB];
    swap_miss   = swap_need_i && !row_filled_i;
    retrace_end = fr_prev_q && !frame_retrace_i;
  end

  assign ctl.cmd_wr    = cmd_wr;
  assign ctl.par_wr    = par_wr;
  assign ctl.st_rd     = st_rd;
  assign ctl.op        = op;
  assign ctl.last_row  = last_row_start_i;
  assign ctl.swap_miss = swap_miss;

  // Screen composition and cursor registers
  logic [7:0] b1_q, b1_d, b2_q, b2_d, b3_q, b3_d, b4_q, b4_d;
  logic [7:0] cchar_q, cchar_d, crow_q, crow_d;
  logic [5:0] hret_q, hret_d;
  logic [2:0] cur_op_q, cur_op_d;

  always_comb begin
    b1_d     = b1_q;
    b2_d     = b2_q;
    b3_d     = b3_q;
    b4_d     = b4_q;
    cchar_d  = cchar_q;
    crow_d   = crow_q;
    hret_d   = hret_q;
    cur_op_d = cmd_wr ? op : cur_op_q;
    if (ctl.par_ok && cur_op_q == crt_pkg::OP_RESET) begin
      unique case (ctl.par_idx)
        crt_pkg::PIDX_0: b1_d = host_wdata_i;
        crt_pkg::PIDX_1: b2_d = host_wdata_i;
        crt_pkg::PIDX_2: b3_d = host_wdata_i;
        crt_pkg::PIDX_3: begin
          b4_d   = host_wdata_i;
          hret_d = crt_pkg::crt_hret(host_wdata_i[3:0]);
        end
        default: ;
      endcase
    end else if (ctl.par_ok && cur_op_q == crt_pkg::OP_CURSOR) begin
      if (ctl.par_idx == crt_pkg::PIDX_0) begin
        cchar_d = host_wdata_i;
      end else begin
        crow_d = host_wdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      b1_q     <= crt_pkg::REG_RESET;
      b2_q     <= crt_pkg::REG_RESET;
      b3_q     <= crt_pkg::REG_RESET;
      b4_q     <= crt_pkg::REG_RESET;
      cchar_q  <= crt_pkg::REG_RESET;
      crow_q   <= crt_pkg::REG_RESET;
      hret_q   <= crt_pkg::HRET_BASE;
      cur_op_q <= crt_pkg::OP_START;
    end else begin
      b1_q     <= b1_d;
      b2_q     <= b2_d;
      b3_q     <= b3_d;
      b4_q     <= b4_d;
      cchar_q  <= cchar_d;
      crow_q   <= crow_d;
      hret_q   <= hret_d;
      cur_op_q <= cur_op_d;
    end
  end

  // Loading, blanking and underrun hold
  logic run_q, run_d, hold_q, hold_d, load_q, load_d, blank_q, blank_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    run_d = run_q;
    if (cmd_wr && op == crt_pkg::OP_RESET) begin
      run_d = 1'b0;
    end else if (cmd_wr && op == crt_pkg::OP_START) begin
      run_d = 1'b1;
    end
    hold_d  = swap_miss || (hold_q && !retrace_end);
    load_d  = run_d && !hold_d;
    blank_d = !ctl.ve || hold_d;
    rdata_d = rdata_q;
    if (st_rd) begin
      rdata_d = 8'h00;
      rdata_d[crt_pkg::ST_IE] = ctl.ie;
      rdata_d[crt_pkg::ST_IR] = ctl.ir;
      rdata_d[crt_pkg::ST_IC] = ctl.ic;
      rdata_d[crt_pkg::ST_VE] = ctl.ve;
      rdata_d[crt_pkg::ST_BU] = ctl.bu;
    end else if (host_rd_i) begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_q     <= 1'b0;
      hold_q    <= 1'b0;
      load_q    <= 1'b0;
      blank_q   <= 1'b1;
      fr_prev_q <= 1'b0;
      rdata_q   <= 8'h00;
    end else begin
      run_q     <= run_d;
      hold_q    <= hold_d;
      load_q    <= load_d;
      blank_q   <= blank_d;
      fr_prev_q <= frame_retrace_i;
      rdata_q   <= rdata_d;
    end
  end

  // Counter preset sequencer
  crt_pkg::crt_preset_t pr_q, pr_d;
  logic [3:0]           pcnt_q, pcnt_d;

  always_comb begin
    pr_d   = pr_q;
    pcnt_d = pcnt_q;
    unique case (pr_q)
      crt_pkg::PR_IDLE: ;
      crt_pkg::PR_LOAD: begin
        pcnt_d = pcnt_q - 4'h1;
        if (pcnt_q == 4'h1) begin
          pr_d = crt_pkg::PR_HOLD;
        end
      end
      crt_pkg::PR_HOLD: ;
      default: pr_d = crt_pkg::PR_IDLE;
    endcase
    if (cmd_wr) begin
      if (op == crt_pkg::OP_PRESET) begin
        pr_d   = crt_pkg::PR_LOAD;
        pcnt_d = 4'(PRESET_CYCLES);
      end else begin
        pr_d = crt_pkg::PR_IDLE;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pr_q   <= crt_pkg::PR_IDLE;
      pcnt_q <= 4'h0;
    end else begin
      pr_q   <= pr_d;
      pcnt_q <= pcnt_d;
    end
  end

  assign host_rdata_o       = rdata_q;
  assign irq_o              = ctl.ir;
  assign row_load_request_o = load_q;
  assign blanking_out_o     = blank_q;
  assign counter_preset_o   = (pr_q == crt_pkg::PR_LOAD);
  assign counters_frozen_o  = (pr_q != crt_pkg::PR_IDLE);
  assign spaced_rows_o      = b1_q[crt_pkg::B1_SPACED];
  assign chars_per_row_o    = b1_q[6:0];
  assign vretrace_rows_o    = b2_q[7:6];
  assign rows_per_frame_o   = b2_q[5:0];
  assign underline_line_o   = b3_q[7:4];
  assign edge_blank_o       = b3_q[4 + crt_pkg::UL_EDGE_BIT];
  assign lines_per_row_o    = b3_q[3:0];
  assign line_mode_o        = b4_q[crt_pkg::B4_MODE];
  assign cursor_format_o    = b4_q[5:4];
  assign hretrace_chars_o   = hret_q;
  assign cursor_char_o      = cchar_q;
  assign cursor_row_o       = crow_q;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cmd(logic [2:0] c);
    cmd_wr && op == c;
  endsequence

  a_reset_blanks: assert property (s_cmd(crt_pkg::OP_RESET) |-> ##2 blanking_out_o && !row_load_request_o)
    else $error("reset command did not blank");
  a_start_flags: assert property (s_cmd(crt_pkg::OP_START) |=> ctl.ie && ctl.ve)
    else $error("start display flags wrong");
  a_stop_keeps_ie: assert property (s_cmd(crt_pkg::OP_STOP) |=> !ctl.ve && ctl.ie == $past(ctl.ie))
    else $error("stop display changed wrong flags");
  a_idis_clears: assert property (s_cmd(crt_pkg::OP_IDIS) |=> !ctl.ie)
    else $error("interrupt disable ignored");
  a_ien_sets: assert property (s_cmd(crt_pkg::OP_IEN) |=> ctl.ie)
    else $error("interrupt enable ignored");
  a_ir_raise: assert property (ctl.ie && last_row_start_i |=> irq_o)
    else $error("request not raised");
  a_irq_read_clear: assert property (st_rd && !(ctl.ie && last_row_start_i) |=> !irq_o)
    else $error("interrupt stayed after read");
  a_preset_two: assert property (s_cmd(crt_pkg::OP_PRESET) ##1 !cmd_wr |->
    counter_preset_o ##1 counter_preset_o ##1 (!counter_preset_o && counters_frozen_o))
    else $error("preset length wrong");
  a_freeze_holds: assert property (counters_frozen_o && !counter_preset_o && !cmd_wr |=> counters_frozen_o)
    else $error("freeze lost without command");
  a_underrun_hold: assert property (swap_miss |=> !row_load_request_o && blanking_out_o ##1 ctl.bu)
    else $error("underrun not handled");
  a_status_word: assert property (st_rd |=> host_rdata_o ==
    {1'b0, $past(ctl.ie), $past(ctl.ir), 1'b0, $past(ctl.ic), $past(ctl.ve), $past(ctl.bu), 1'b0})
    else $error("status layout wrong");
  a_cursor_load: assert property (s_cmd(crt_pkg::OP_CURSOR) ##1 (par_wr && !cmd_wr) |=>
    cursor_char_o == $past(host_wdata_i)) else $error("cursor column not stored");
endmodule

// [sim/crt_host.sv]
/*
 * Host processor model for the CRT command port: single byte writes and
 * status reads on the register select bus.
 * Assumes the bench calls its tasks only after reset has been released.
 */
`timescale 1ns/1ps
module crt_host (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] host_rdata_i,
  output logic            host_wr_o,
  output logic            host_rd_o,
  output logic            cmd_select_o,
  output logic      [7:0] host_wdata_o
);
  initial begin
    host_wr_o    = 1'b0;
    host_rd_o    = 1'b0;
    cmd_select_o = 1'b0;
    host_wdata_o = 8'h5a;
  end

  // One write strobe; select high command, low parameter
  task automatic put(input logic sel, input logic [7:0] data);
    @(posedge ref_clk_i);
    #1;
    host_wr_o    = 1'b1;
    cmd_select_o = sel;
    host_wdata_o = data;
    @(posedge ref_clk_i);
    #1;
    host_wr_o    = 1'b0;
    cmd_select_o = ~sel;
    host_wdata_o = ~data;
  endtask

  // One read strobe; data taken the cycle after
  task automatic get(input logic sel, output logic [7:0] data);
    @(posedge ref_clk_i);
    #1;
    host_rd_o    = 1'b1;
    cmd_select_o = sel;
    @(posedge ref_clk_i);
    #1;
    host_rd_o    = 1'b0;
    cmd_select_o = ~sel;
    data         = host_rdata_i;
  endtask
endmodule

// [sim/crt_cmd_port_tb.sv]
/*
 * Self-checking bench for the CRT command and status port.
 * Assumes the host model drives the register bus and this bench drives
 * the raster side signals one nanosecond after each rising edge.
 */
`timescale 1ns/1ps
module crt_cmd_port_tb;
  logic       ref_clk_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic       lrs       = 1'b0;
  logic       swp       = 1'b0;
  logic       filled    = 1'b0;
  logic       fret      = 1'b0;
  logic       host_wr, host_rd, cmd_sel;
  logic [7:0] wdata, rdata, st, cur_c, cur_r;
  logic       irq, load, blank, pre, frz, spaced, ublank, lmode;
  logic [6:0] cpr;
  logic [5:0] rpf, hret;
  logic [3:0] ul, lpr;
  logic [1:0] vr, cf;
  int         errors      = 0;
  int         comparisons = 0;
  logic [7:0] tb1 [4]     = '{8'hcf, 8'h00, 8'h4f, 8'h85};
  logic [7:0] tb2 [4]     = '{8'hff, 8'h00, 8'h5a, 8'h81};
  logic [7:0] tb3 [4]     = '{8'h9a, 8'h7f, 8'hf0, 8'h00};
  logic [7:0] tb4 [4]     = '{8'h80, 8'h15, 8'ha9, 8'h3f};

  always #2 ref_clk_i = ~ref_clk_i;

  crt_host host (.ref_clk_i(ref_clk_i), .host_rdata_i(rdata), .host_wr_o(host_wr), .host_rd_o(host_rd),
                 .cmd_select_o(cmd_sel), .host_wdata_o(wdata));

  crt_cmd_port dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .host_wr_i(host_wr), .host_rd_i(host_rd),
    .cmd_select_i(cmd_sel), .host_wdata_i(wdata), .last_row_start_i(lrs), .swap_need_i(swp),
    .row_filled_i(filled), .frame_retrace_i(fret), .host_rdata_o(rdata), .irq_o(irq),
    .row_load_request_o(load), .blanking_out_o(blank), .counter_preset_o(pre), .counters_frozen_o(frz),
    .spaced_rows_o(spaced), .chars_per_row_o(cpr), .vretrace_rows_o(vr), .rows_per_frame_o(rpf),
    .underline_line_o(ul), .edge_blank_o(ublank), .lines_per_row_o(lpr), .line_mode_o(lmode),
    .cursor_format_o(cf), .hretrace_chars_o(hret), .cursor_char_o(cur_c), .cursor_row_o(cur_r));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic stat(input logic [7:0] exp);
    host.get(1'b1, st);
    chk(st, exp);
  endtask

  task automatic row_pulse();
    lrs = 1'b1;
    tick(1);
    lrs = 1'b0;
  endtask

  task automatic t_after_reset();
    chk({3'h0, blank, load, irq, pre, frz}, 8'h10);
    chk({2'h0, hret}, 8'h02);
    stat(8'h00);
    host.get(1'b0, st);
    chk(st, 8'h00);
    $display("test after_reset done");
  endtask

  task automatic t_config(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3,
                          input logic [7:0] b4);
    host.put(1'b1, 8'h00);
    host.put(1'b0, b1);
    host.put(1'b0, b2);
    host.put(1'b0, b3);
    host.put(1'b0, b4);
    tick(1);
    chk({spaced, cpr}, b1);
    chk({vr, rpf}, b2);
    chk({ul, lpr}, b3);
    chk({7'h0, ublank}, {7'h0, b3[7]});
    chk({7'h0, lmode}, {7'h0, b4[7]});
    chk({6'h0, cf}, {6'h0, b4[5:4]});
    chk({2'h0, hret}, {3'h0, b4[3:0], 1'b0} + 8'h02);
    chk({6'h0, blank, load}, 8'h02);
    stat(8'h00);
    $display("test config done");
  endtask

  task automatic t_display();
    host.put(1'b1, 8'h20);
    chk({7'h0, load}, 8'h01);
    tick(1);
    chk({7'h0, blank}, 8'h00);
    stat(8'h44);
    host.put(1'b1, 8'h40);
    tick(1);
    chk({6'h0, blank, load}, 8'h03);
    stat(8'h40);
    host.put(1'b1, 8'h20);
    stat(8'h44);
    $display("test display done");
  endtask

  task automatic t_irq();
    host.put(1'b1, 8'hc0);
    stat(8'h04);
    row_pulse();
    chk({7'h0, irq}, 8'h00);
    host.put(1'b1, 8'ha0);
    stat(8'h44);
    row_pulse();
    chk({7'h0, irq}, 8'h01);
    stat(8'h64);
    chk({7'h0, irq}, 8'h00);
    stat(8'h44);
    row_pulse();
    host.put(1'b1, 8'h00);
    chk({6'h0, irq, load}, 8'h00);
    tick(1);
    chk({7'h0, blank}, 8'h01);
    repeat (4) host.put(1'b0, 8'h00);
    stat(8'h00);
    $display("test irq done");
  endtask

  task automatic t_cursor();
    host.put(1'b1, 8'h20);
    host.put(1'b1, 8'h80);
    host.put(1'b0, 8'h4f);
    host.put(1'b0, 8'h17);
    tick(1);
    chk(cur_c, 8'h4f);
    chk(cur_r, 8'h17);
    stat(8'h44);
    $display("test cursor done");
  endtask

  task automatic t_badseq();
    host.put(1'b1, 8'h80);
    host.put(1'b0, 8'h3c);
    host.put(1'b1, 8'ha0);
    stat(8'h4c);
    stat(8'h44);
    host.put(1'b1, 8'h80);
    host.put(1'b0, 8'h01);
    host.put(1'b0, 8'h02);
    host.put(1'b0, 8'h03);
    tick(1);
    chk(cur_r, 8'h02);
    stat(8'h4c);
    host.put(1'b0, 8'h55);
    stat(8'h4c);
    $display("test badseq done");
  endtask

  task automatic t_preset();
    host.put(1'b1, 8'he0);
    chk({6'h0, pre, frz}, 8'h03);
    tick(1);
    chk({6'h0, pre, frz}, 8'h03);
    tick(1);
    chk({6'h0, pre, frz}, 8'h01);
    tick(5);
    chk({6'h0, pre, frz}, 8'h01);
    host.put(1'b1, 8'ha0);
    tick(1);
    chk({6'h0, pre, frz}, 8'h00);
    $display("test preset done");
  endtask

  task automatic t_underrun();
    filled = 1'b1;
    swp    = 1'b1;
    tick(1);
    swp    = 1'b0;
    tick(1);
    chk({6'h0, blank, load}, 8'h01);
    filled = 1'b0;
    swp    = 1'b1;
    tick(1);
    swp    = 1'b0;
    chk({6'h0, blank, load}, 8'h02);
    fret   = 1'b1;
    tick(6);
    chk({6'h0, blank, load}, 8'h02);
    stat(8'h46);
    stat(8'h44);
    fret   = 1'b0;
    tick(3);
    chk({6'h0, blank, load}, 8'h01);
    $display("test underrun done");
  endtask

  initial begin
    #20000;
    errors++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    t_after_reset();
    for (int i = 0; i < 4; i++) begin
      t_config(tb1[i], tb2[i], tb3[i], tb4[i]);
    end
    t_display();
    t_irq();
    t_cursor();
    t_badseq();
    t_preset();
    t_underrun();
    close_out();
  end
endmodule
